// ===== iocfg_params.svh
`ifndef IOCFG_PARAMS_SVH
`define IOCFG_PARAMS_SVH
`define IOCFG_IDX_PINFN     8'h03
`define IOCFG_IDX_SETUP     8'h04
`define IOCFG_IDX_RSVD5     8'h05
`define IOCFG_IDX_RSVD6     8'h06
`define IOCFG_IDX_APM       8'h07
`define IOCFG_IDX_DECLO     8'h08
`define IOCFG_IDX_DECHI     8'h09
`define IOCFG_RST_PINFN     8'h70
`define IOCFG_RST_SETUP     8'h00
`define IOCFG_RST_RSVD5     8'h00
`define IOCFG_RST_RSVD6     8'hFF
`define IOCFG_RST_APM       8'h00
`define IOCFG_RST_DECLO     8'h00
`define IOCFG_RST_DECHI     8'h00
`define IOCFG_PR_PRINTER    1'b1
`define IOCFG_RST_PPMODE    1'b1
`define IOCFG_RST_ECR       3'h0
`define IOCFG_PINFN_WMASK   8'h85
`define IOCFG_PINFN_ONES    8'h70
`define IOCFG_SETUP_WMASK   8'h73
`define IOCFG_APM_WMASK     8'h70
`define IOCFG_DECLO_WMASK   8'hF0
`define IOCFG_DECHI_WMASK   8'hC7
`define IOCFG_ECR_SPP       3'h0
`define IOCFG_ECR_EPP       3'h4
`define IOCFG_DIV_STD       4'hD
`define IOCFG_DIV_MIDI      4'hC
`define IOCFG_OVERSAMPLE    5'h10
`define IOCFG_BASE_MIN      11'h100
`define IOCFG_NIB_ZERO      4'h0
`define IOCFG_BIT_PP_MODE   3
`define IOCFG_BIT_MIDI1     4
`define IOCFG_BIT_MIDI2     5
`define IOCFG_BIT_EPPTYPE   6
`define IOCFG_BIT_APM_PP    4
`define IOCFG_BIT_APM_U2    5
`define IOCFG_BIT_APM_U1    6
`define IOCFG_BIT_PIN_HI    7
`define IOCFG_BIT_PIN_LO    2
`define IOCFG_BIT_A3        3
`endif

// ===== iocfg_pkg.sv
package iocfg_pkg;
	typedef enum logic [1:0] {
		IOCFG_PP_SPP,
		IOCFG_PP_EPP_SPP,
		IOCFG_PP_ECP,
		IOCFG_PP_ECP_EPP
	} iocfg_pp_sel_t;
	typedef enum logic [1:0] {
		IOCFG_DEC_OFF,
		IOCFG_DEC_BYTE,
		IOCFG_DEC_BLK8,
		IOCFG_DEC_BLK16
	} iocfg_dec_mode_t;
	typedef enum logic [1:0] {
		IOCFG_PIN_DEFAULT,
		IOCFG_PIN_RSVD,
		IOCFG_PIN_STROBE,
		IOCFG_PIN_IRQ
	} iocfg_pin_sel_t;
	typedef enum {
		IOCFG_OP_PRINTER,
		IOCFG_OP_SPP,
		IOCFG_OP_EPP,
		IOCFG_OP_ECP
	} iocfg_op_t;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] idx;
		logic [7:0] wdata;
	} iocfg_req_t;
	typedef struct packed {
		logic       ecr_wr;
		logic [2:0] ecr_mode;
	} iocfg_ecr_t;
	typedef struct packed {
		logic [1:0] pp_mode;
		logic       epp_v17;
		logic [3:0] u1_div;
		logic [3:0] u2_div;
		logic       apd_pp;
		logic       apd_u2;
		logic       apd_u1;
	} iocfg_ctl_t;
endpackage

// ===== iocfg_regs.sv
// How it works
// - access only in config state, matching index
// - pin-function register resets to 70H
// - pin-function reserved bits read fixed values
// - setup bits 1:0 select parallel extended mode
// - midi bits pick divide 12 or 13
// - setup bit 6 picks epp version
// - ecr mode 100 selects epp in combo
// - ecr mode 000 selects spp in ecp
// - divide 12 then 16 gives midi rate
// - power-management bits enable auto power-down
// - reset clears auto power-down enables
// - low decode register holds address bits 7:4
// - low decode bits 3:0 ignored, read zero
// - high decode holds bits 10:8 and mode
// - decoder mode selects nibble match pattern
// - strobe only while chip select low
// - power-down keeps decode; base below 100h stops
// - powered-down device still range-checked
// - reserved indexes five and six reset values
// - setup register resets 00H, reserved bits zero
// - printer-mode bit low enables extended modes
`include "iocfg_params.svh"
module iocfg_regs (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 config_state,
	input  iocfg_pkg::iocfg_req_t     req,
	input  iocfg_pkg::iocfg_ecr_t     ecr,
	input  wire logic                 parallel_power_register_mode,
	input  wire logic [10:0]          host_addr,
	input  wire logic                 chip_select_n,
	input  wire logic                 power_good_input,
	input  wire logic                 irq_b_in,
	input  wire logic [10:0]          pp_base,
	input  wire logic                 pp_power_down,
	output logic [7:0]                rdata_ff,
	output logic                      rvalid_ff,
	output iocfg_pkg::iocfg_ctl_t     ctl_ff,
	output iocfg_pkg::iocfg_op_t      pp_op_ff,
	output logic                      aux_decode_strobe_ff,
	output logic                      shared_pin_ff,
	output logic                      pp_decode_en_ff,
	output logic                      pp_range_check_ff
);
	import iocfg_pkg::*;

	logic [7:0]      pinfn_ff, nxt_pinfn;
	logic [7:0]      setup_ff, nxt_setup;
	logic [7:0]      rsvd5_ff, nxt_rsvd5;
	logic [7:0]      rsvd6_ff, nxt_rsvd6;
	logic [7:0]      apm_ff, nxt_apm;
	logic [7:0]      declo_ff, nxt_declo;
	logic [7:0]      dechi_ff, nxt_dechi;
	logic [2:0]      ecr_mode_ff, nxt_ecr_mode;
	logic [7:0]      nxt_rdata;
	logic            nxt_rvalid;
	iocfg_ctl_t      nxt_ctl;
	iocfg_op_t       nxt_pp_op;
	logic            nxt_strobe;
	logic            nxt_pin;
	logic            nxt_dec_en;
	logic            nxt_range;
	logic            dec_hit;
	logic            acc_wr;
	logic            acc_rd;

	// masked write: only writable bits take the new value
	function automatic logic [7:0] mwr(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
		mwr = (old & ~m) | (wd & m);
	endfunction

	function automatic logic [3:0] div_of(input logic midi);
		div_of = midi ? `IOCFG_DIV_MIDI : `IOCFG_DIV_STD;
	endfunction

	// register storage and host access
	always_comb begin
		acc_wr = config_state && req.wr;
		acc_rd = config_state && req.rd;
		nxt_pinfn = pinfn_ff;
		nxt_setup = setup_ff;
		nxt_rsvd5 = rsvd5_ff;
		nxt_rsvd6 = rsvd6_ff;
		nxt_apm = apm_ff;
		nxt_declo = declo_ff;
		nxt_dechi = dechi_ff;
		nxt_rdata = rdata_ff;
		nxt_rvalid = 1'b0;
		nxt_ecr_mode = ecr_mode_ff;
		if (ecr.ecr_wr) begin
			nxt_ecr_mode = ecr.ecr_mode;
		end
		if (acc_wr) begin
			case (req.idx)
				`IOCFG_IDX_PINFN: nxt_pinfn = mwr(pinfn_ff, req.wdata, `IOCFG_PINFN_WMASK);
				`IOCFG_IDX_SETUP: nxt_setup = mwr(setup_ff, req.wdata, `IOCFG_SETUP_WMASK);
				`IOCFG_IDX_APM: nxt_apm = mwr(apm_ff, req.wdata, `IOCFG_APM_WMASK);
				`IOCFG_IDX_DECLO: nxt_declo = mwr(declo_ff, req.wdata, `IOCFG_DECLO_WMASK);
				`IOCFG_IDX_DECHI: nxt_dechi = mwr(dechi_ff, req.wdata, `IOCFG_DECHI_WMASK);
				default: begin
					// reserved and unknown indexes keep their values
				end
			endcase
		end
		if (acc_rd) begin
			nxt_rvalid = 1'b1;
			case (req.idx)
				`IOCFG_IDX_PINFN: nxt_rdata = (pinfn_ff & `IOCFG_PINFN_WMASK) | `IOCFG_PINFN_ONES;
				`IOCFG_IDX_SETUP: nxt_rdata = setup_ff & `IOCFG_SETUP_WMASK;
				`IOCFG_IDX_RSVD5: nxt_rdata = rsvd5_ff;
				`IOCFG_IDX_RSVD6: nxt_rdata = rsvd6_ff;
				`IOCFG_IDX_APM: nxt_rdata = apm_ff & `IOCFG_APM_WMASK;
				`IOCFG_IDX_DECLO: nxt_rdata = declo_ff & `IOCFG_DECLO_WMASK;
				`IOCFG_IDX_DECHI: nxt_rdata = dechi_ff & `IOCFG_DECHI_WMASK;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// derived controls and parallel operating mode
	always_comb begin
		nxt_ctl.pp_mode = setup_ff[1:0];
		nxt_ctl.epp_v17 = setup_ff[`IOCFG_BIT_EPPTYPE];
		nxt_ctl.u1_div = div_of(setup_ff[`IOCFG_BIT_MIDI1]);
		nxt_ctl.u2_div = div_of(setup_ff[`IOCFG_BIT_MIDI2]);
		nxt_ctl.apd_pp = apm_ff[`IOCFG_BIT_APM_PP];
		nxt_ctl.apd_u2 = apm_ff[`IOCFG_BIT_APM_U2];
		nxt_ctl.apd_u1 = apm_ff[`IOCFG_BIT_APM_U1];
		if (parallel_power_register_mode == `IOCFG_PR_PRINTER) begin
			nxt_pp_op = IOCFG_OP_PRINTER;
		end else begin
			case (iocfg_pp_sel_t'(setup_ff[1:0]))
				IOCFG_PP_SPP: nxt_pp_op = IOCFG_OP_SPP;
				IOCFG_PP_EPP_SPP: nxt_pp_op = IOCFG_OP_EPP;
				IOCFG_PP_ECP: nxt_pp_op = (ecr_mode_ff == `IOCFG_ECR_SPP) ? IOCFG_OP_SPP : IOCFG_OP_ECP;
				IOCFG_PP_ECP_EPP: begin
					if (ecr_mode_ff == `IOCFG_ECR_EPP) begin
						nxt_pp_op = IOCFG_OP_EPP;
					end else if (ecr_mode_ff == `IOCFG_ECR_SPP) begin
						nxt_pp_op = IOCFG_OP_SPP;
					end else begin
						nxt_pp_op = IOCFG_OP_ECP;
					end
				end
				default: nxt_pp_op = IOCFG_OP_PRINTER;
			endcase
		end
		// power-down input is unused; only the base address gates the address decode
		nxt_dec_en = (pp_base >= `IOCFG_BASE_MIN);
		nxt_range = nxt_dec_en;
	end

	// decoder and shared pin; registered, so one cycle behind the bus
	always_comb begin
		dec_hit = (host_addr[10:8] == dechi_ff[2:0]) && (host_addr[7:4] == declo_ff[7:4]);
		case (iocfg_dec_mode_t'(dechi_ff[7:6]))
			IOCFG_DEC_OFF: nxt_strobe = 1'b0;
			IOCFG_DEC_BYTE: nxt_strobe = dec_hit && (host_addr[3:0] == `IOCFG_NIB_ZERO);
			IOCFG_DEC_BLK8: nxt_strobe = dec_hit && !host_addr[`IOCFG_BIT_A3];
			IOCFG_DEC_BLK16: nxt_strobe = dec_hit;
			default: nxt_strobe = 1'b0;
		endcase
		nxt_strobe = nxt_strobe && !chip_select_n;
		case (iocfg_pin_sel_t'({pinfn_ff[`IOCFG_BIT_PIN_HI], pinfn_ff[`IOCFG_BIT_PIN_LO]}))
			IOCFG_PIN_DEFAULT: nxt_pin = power_good_input;
			IOCFG_PIN_STROBE: nxt_pin = nxt_strobe;
			IOCFG_PIN_IRQ: nxt_pin = irq_b_in;
			default: nxt_pin = 1'b0;
		endcase
	end

	// register storage and host access
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinfn_ff <= `IOCFG_RST_PINFN;
			setup_ff <= `IOCFG_RST_SETUP;
			rsvd5_ff <= `IOCFG_RST_RSVD5;
			rsvd6_ff <= `IOCFG_RST_RSVD6;
			apm_ff <= `IOCFG_RST_APM;
			declo_ff <= `IOCFG_RST_DECLO;
			dechi_ff <= `IOCFG_RST_DECHI;
			ecr_mode_ff <= `IOCFG_RST_ECR;
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			pinfn_ff <= nxt_pinfn;
			setup_ff <= nxt_setup;
			rsvd5_ff <= nxt_rsvd5;
			rsvd6_ff <= nxt_rsvd6;
			apm_ff <= nxt_apm;
			declo_ff <= nxt_declo;
			dechi_ff <= nxt_dechi;
			ecr_mode_ff <= nxt_ecr_mode;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	// derived controls and parallel operating mode
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl_ff <= '0;
			pp_op_ff <= IOCFG_OP_PRINTER;
			pp_decode_en_ff <= 1'b0;
			pp_range_check_ff <= 1'b0;
		end else begin
			ctl_ff <= nxt_ctl;
			pp_op_ff <= nxt_pp_op;
			pp_decode_en_ff <= nxt_dec_en;
			pp_range_check_ff <= nxt_range;
		end
	end

	// decoder strobe and shared pin
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aux_decode_strobe_ff <= 1'b0;
			shared_pin_ff <= 1'b0;
		end else begin
			aux_decode_strobe_ff <= nxt_strobe;
			shared_pin_ff <= nxt_pin;
		end
	end
endmodule // iocfg_regs

// ===== iocfg_regs_chk.sv
module iocfg_regs_chk (
	input wire logic             clock,
	input wire logic             rst_n,
	input wire logic             config_state,
	input iocfg_pkg::iocfg_req_t req,
	input wire logic             chip_select_n,
	input wire logic [10:0]      pp_base,
	input wire logic [7:0]       rdata_ff,
	input wire logic             rvalid_ff,
	input wire logic             aux_decode_strobe_ff,
	input wire logic             pp_decode_en_ff,
	input wire logic             pp_range_check_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	import iocfg_pkg::*;
	default clocking dc @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_read_answered: assert property (config_state && req.rd |=> rvalid_ff) else $error("read not answered");
	a_closed_read: assert property (!config_state |=> !rvalid_ff) else $error("read outside config");
	a_pinfn_fixed: assert property (rvalid_ff && $past(req.idx) == 8'h03 |-> rdata_ff[6:3] == 4'hE && !rdata_ff[1])
		else $error("pin select fixed bits");
	a_setup_rsvd: assert property (rvalid_ff && $past(req.idx) == 8'h04 |-> (rdata_ff & 8'h8C) == 8'h00)
		else $error("setup reserved bits");
	a_apm_rsvd: assert property (rvalid_ff && $past(req.idx) == 8'h07 |-> (rdata_ff & 8'h8F) == 8'h00)
		else $error("power reserved bits");
	a_declo_nibble: assert property (rvalid_ff && $past(req.idx) == 8'h08 |-> rdata_ff[3:0] == 4'h0)
		else $error("decode low nibble");
	a_six_const: assert property (rvalid_ff && $past(req.idx) == 8'h06 |-> rdata_ff == 8'hFF)
		else $error("index six value");
	a_strobe_qual: assert property (chip_select_n |=> !aux_decode_strobe_ff) else $error("strobe unqualified");
	a_base_high: assert property (pp_base >= 11'h100 |=> pp_decode_en_ff && pp_range_check_ff)
		else $error("decode off at valid base");
	a_base_low: assert property (pp_base < 11'h100 |=> !pp_decode_en_ff) else $error("decode on at low base");
	cover property (config_state && req.rd ##1 rvalid_ff);
	cover property (!chip_select_n ##1 aux_decode_strobe_ff);
	cover property ($rose(pp_decode_en_ff));
endmodule // iocfg_regs_chk

// ===== iocfg_host_model.sv
module iocfg_host_model (
	input wire logic        clock,
	input wire logic        cyc_en,
	input wire logic [10:0] cyc_addr,
	output logic [10:0]     host_addr,
	output logic            chip_select_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		host_addr = 11'h7FF;
		chip_select_n = 1'b1;
	end
	// address lines stay driven between cycles; only chip select marks a host cycle
	always @(posedge clock) begin
		chip_select_n <= !cyc_en;
		host_addr <= cyc_addr;
	end
endmodule // iocfg_host_model

// ===== iocfg_regs_test.sv
module iocfg_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import iocfg_pkg::*;
	logic        clock = 1'b0, rst_n = 1'b0, cfg = 1'b0, pr_mode = 1'b1, irq_b = 1'b0, cyc_en = 1'b0, pp_pd = 1'b0;
	iocfg_req_t  req = '0;
	iocfg_ecr_t  ecr = '0;
	logic [10:0] cyc_addr = '0, pp_base = '0, host_addr;
	logic        pg = 1'b0;
	logic        cs_n, rvalid, strobe, pin, dec_en, rng;
	logic [7:0]  rdata;
	iocfg_ctl_t  ctl;
	iocfg_op_t   pp_op;
	int          failures = 0, check_count = 0;
	localparam logic [7:0] IX[7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
	localparam logic [7:0] DV[7] = '{8'h70, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] FV[7] = '{8'hF5, 8'h73, 8'h00, 8'hFF, 8'h70, 8'hF0, 8'hC7};
	iocfg_host_model host (.clock(clock), .cyc_en(cyc_en), .cyc_addr(cyc_addr), .host_addr(host_addr),
		.chip_select_n(cs_n));
	iocfg_regs dut (.clock(clock), .rst_n(rst_n), .config_state(cfg), .req(req), .ecr(ecr),
		.parallel_power_register_mode(pr_mode), .host_addr(host_addr), .chip_select_n(cs_n),
		.power_good_input(pg), .irq_b_in(irq_b), .pp_base(pp_base), .pp_power_down(pp_pd), .rdata_ff(rdata),
		.rvalid_ff(rvalid), .ctl_ff(ctl), .pp_op_ff(pp_op), .aux_decode_strobe_ff(strobe), .shared_pin_ff(pin),
		.pp_decode_en_ff(dec_en), .pp_range_check_ff(rng));
	always #50 clock = ~clock;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(posedge clock);
		req <= '{wr: 1'b1, rd: 1'b0, idx: i, wdata: d};
		@(posedge clock);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b1, idx: i, wdata: 8'h00};
		@(posedge clock);
		req.rd <= 1'b0;
		#1;
		chk(16'({rvalid, rdata}), 16'({1'b1, e}));
	endtask
	task automatic dec(input logic c, input logic [10:0] a, input logic e);
		@(posedge clock);
		cyc_en <= c;
		cyc_addr <= a;
		settle(3);
		chk(16'(strobe), 16'(e));
	endtask
	task automatic ecr_set(input logic [2:0] m, input iocfg_op_t e);
		@(posedge clock);
		ecr <= '{ecr_wr: 1'b1, ecr_mode: m};
		@(posedge clock);
		ecr.ecr_wr <= 1'b0;
		settle(2);
		chk(16'(pp_op), 16'(e));
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		cfg <= 1'b1;
		for (int k = 0; k < 7; k++) wr(IX[k], 8'hFF);
		for (int k = 0; k < 7; k++) rd(IX[k], FV[k]);
		rd(8'h0A, 8'h00);
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		for (int k = 0; k < 7; k++) rd(IX[k], DV[k]);
		@(posedge clock);
		cfg <= 1'b0;
		wr(8'h07, 8'h70);
		@(posedge clock);
		req.rd <= 1'b1;
		@(posedge clock);
		req.rd <= 1'b0;
		#1;
		chk(16'(rvalid), 16'h0);
		@(posedge clock);
		cfg <= 1'b1;
		rd(8'h07, 8'h00);
		wr(8'h04, 8'h71);
		settle(2);
		chk(16'({ctl.pp_mode, ctl.epp_v17, ctl.u1_div, ctl.u2_div}), 16'h3CC);
		@(posedge clock);
		pr_mode <= 1'b0;
		wr(8'h04, 8'h03);
		settle(2);
		chk(16'({ctl.pp_mode, ctl.epp_v17, ctl.u1_div, ctl.u2_div}), 16'h6DD);
		ecr_set(3'h4, IOCFG_OP_EPP);
		ecr_set(3'h0, IOCFG_OP_SPP);
		ecr_set(3'h3, IOCFG_OP_ECP);
		wr(8'h04, 8'h02);
		settle(2);
		chk(16'(pp_op), 16'(IOCFG_OP_ECP));
		ecr_set(3'h0, IOCFG_OP_SPP);
		wr(8'h04, 8'h01);
		settle(2);
		chk(16'(pp_op), 16'(IOCFG_OP_EPP));
		wr(8'h04, 8'h00);
		settle(2);
		chk(16'(pp_op), 16'(IOCFG_OP_SPP));
		@(posedge clock);
		pr_mode <= 1'b1;
		settle(2);
		chk(16'(pp_op), 16'(IOCFG_OP_PRINTER));
		wr(8'h08, 8'h30);
		wr(8'h09, 8'h41);
		dec(1'b1, 11'h130, 1'b1);
		dec(1'b1, 11'h131, 1'b0);
		dec(1'b0, 11'h130, 1'b0);
		wr(8'h09, 8'h81);
		dec(1'b1, 11'h137, 1'b1);
		dec(1'b1, 11'h138, 1'b0);
		wr(8'h09, 8'hC1);
		dec(1'b1, 11'h13F, 1'b1);
		wr(8'h03, 8'h80);
		settle(3);
		chk(16'(pin), 16'h1);
		dec(1'b1, 11'h03F, 1'b0);
		chk(16'(pin), 16'h0);
		wr(8'h09, 8'h01);
		dec(1'b1, 11'h130, 1'b0);
		@(posedge clock);
		irq_b <= 1'b1;
		wr(8'h03, 8'h84);
		settle(3);
		chk(16'(pin), 16'h1);
		wr(8'h03, 8'h04);
		settle(3);
		chk(16'(pin), 16'h0);
		@(posedge clock);
		pg <= 1'b1;
		irq_b <= 1'b0;
		wr(8'h03, 8'h00);
		settle(3);
		chk(16'(pin), 16'h1);
		@(posedge clock);
		pp_base <= 11'h0FF;
		pp_pd <= 1'b1;
		settle(2);
		chk(16'({dec_en, rng}), 16'h0);
		@(posedge clock);
		pp_base <= 11'h100;
		settle(2);
		chk(16'({dec_en, rng}), 16'h3);
		@(posedge clock);
		pp_base <= 11'h378;
		settle(2);
		chk(16'({dec_en, rng}), 16'h3);
		finish_test;
	end
	initial begin
		repeat (3000) @(posedge clock);
		failures++;
		finish_test;
	end
endmodule // iocfg_regs_test
bind iocfg_regs iocfg_regs_chk u_chk (.clock(clock), .rst_n(rst_n), .config_state(config_state), .req(req),
	.chip_select_n(chip_select_n), .pp_base(pp_base), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff),
	.aux_decode_strobe_ff(aux_decode_strobe_ff), .pp_decode_en_ff(pp_decode_en_ff),
	.pp_range_check_ff(pp_range_check_ff));
